// [hw/tpwm_cfg.svh]
// constants for the three-phase pwm timer compare block
`ifndef TPWM_CFG_SVH
`define TPWM_CFG_SVH
`define TPWM_CNT_W 16
`define TPWM_NCH 3
`define TPWM_ADDR_W 4
// register offsets (word index on the plain port)
`define TPWM_OFF_CTRL 4'h0
`define TPWM_OFF_STAT 4'h1
`define TPWM_OFF_PERIOD 4'h2
`define TPWM_OFF_CMP0 4'h3
`define TPWM_OFF_CMP1 4'h4
`define TPWM_OFF_CMP2 4'h5
`define TPWM_OFF_MODE 4'h6
`define TPWM_OFF_STCMD 4'h7
`define TPWM_OFF_COUNT 4'h8
// ctrl fields
`define TPWM_CTRL_ALIGN 0
`define TPWM_CTRL_SSHOT 1
`define TPWM_CTRL_RUN_SET 2
`define TPWM_CTRL_RUN_CLR 3
`define TPWM_CTRL_XFER 4
// status fields
`define TPWM_STAT_RUN 0
`define TPWM_STAT_DIR 1
`define TPWM_STAT_ST 4
// state command fields: set bits 0..2, clear bits 4..6
`define TPWM_STCMD_SET 0
`define TPWM_STCMD_CLR 4
// channel mode encodings (4 bits per channel)
`define TPWM_MODE_NORMAL 4'h1
`define TPWM_MODE_HYST 4'h9
`define TPWM_CNT_ZERO 16'h0000
`define TPWM_CNT_ONE 16'h0001
`endif

// [hw/tpwm_pkg.sv]
// types for the three-phase pwm timer compare block
package tpwm_pkg;
  typedef struct packed {
    logic align_select;
    logic single_shot_ctl;
  } tpwm_ctrl_type;
  typedef struct packed {
    logic [2:0] cmp_rise_evt;
    logic [2:0] cmp_fall_evt;
  } tpwm_evt_type;
endpackage

// [hw/tpwm_timer.sv]
// three-phase pwm timer with compare channels and state bits
//
// Function
// - edge-aligned mode counts only up, direction flag held at zero.
// - edge-aligned: tick after period match clears counter to zero.
// - edge-aligned period lasts period value plus one ticks.
// - center-aligned: period match counting up sets direction down next tick.
// - center-aligned: one match counting down sets direction up next tick.
// - center-aligned period lasts twice period value plus two ticks.
// - counter counts by direction flag; flag lags match by one tick.
// - single-shot control makes hardware clear run flag at period end.
// - edge-aligned single shot stops when counter wraps to zero.
// - center-aligned single shot stops on reaching zero counting down.
// - each channel compares counter against its active compare value.
// - software writes shadow compare; shadow transfer copies to active.
// - software set and clear commands override compare rules on each channel state bit.
// - normal mode ignores the hysteresis input.
// - match counting up gives rise event, counting down fall event.
// - compare-driven state changes only while the run flag is set.
// - state set after up match, or zero match with compare match.
// - state cleared after down match, or zero match without match.
// - compare value zero keeps state at one, full duty.
// - compare value period plus one never sets state, zero duty.
// - hysteresis mode holds state at zero while its input is low.
// - hysteresis inputs sampled on module clock, not the timer tick.
// - zero match and one match signals derived from counter.
// - period reads show active value; writes go to shadow period.
`timescale 1ns/1ps
`include "tpwm_cfg.svh"

module tpwm_timer
  import tpwm_pkg::*;
#(
  parameter int CNT_W = `TPWM_CNT_W,
  parameter int NCH = `TPWM_NCH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic timer_tick,
  input wire logic [NCH-1:0] hyst_input,
  input wire logic [`TPWM_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [NCH-1:0] channel_state,
  output tpwm_evt_type cmp_evt,
  output logic period_match,
  output logic zero_match,
  output logic one_match,
  output logic run_flag
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && reg_addr == `TPWM_OFF_CTRL;
  wire wr_period = reg_wr && reg_addr == `TPWM_OFF_PERIOD;
  wire wr_mode = reg_wr && reg_addr == `TPWM_OFF_MODE;
  wire wr_stcmd = reg_wr && reg_addr == `TPWM_OFF_STCMD;
  wire wr_count = reg_wr && reg_addr == `TPWM_OFF_COUNT;
  // command strobes act in the write cycle only and are not stored
  wire run_set = wr_ctrl && reg_wdata[`TPWM_CTRL_RUN_SET];
  wire run_clr = wr_ctrl && reg_wdata[`TPWM_CTRL_RUN_CLR];
  wire shadow_xfer = wr_ctrl && reg_wdata[`TPWM_CTRL_XFER];

  tpwm_ctrl_type ctrl_r;
  logic run_r, run_nxt;
  logic count_dir_flag_r, dir_nxt;
  logic [CNT_W-1:0] pwm_counter_r, cnt_nxt;
  logic [CNT_W-1:0] period_reg_r, period_shadow_r;
  logic [CNT_W-1:0] compare_value_r [NCH];
  logic [CNT_W-1:0] compare_shadow_r [NCH];
  logic [4*NCH-1:0] channel_mode_sel_r;
  logic [NCH-1:0] state_r;
  logic [NCH-1:0] hyst_s_r;
  logic [NCH-1:0] compare_match;
  logic [NCH-1:0] rise_r, fall_r;

  // ----------------------------------------------------------------
  // counter and direction
  // ----------------------------------------------------------------
  // match decode
  assign zero_match = pwm_counter_r == `TPWM_CNT_ZERO;
  assign one_match = pwm_counter_r == `TPWM_CNT_ONE;
  assign period_match = pwm_counter_r == period_reg_r;
  assign run_flag = run_r;

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  wire counting_down = count_dir_flag_r;
  wire step = run_r && timer_tick;
  // center single shot ends as the count goes from one to zero
  wire ca_end = ctrl_r.align_select && counting_down && one_match;
  // edge single shot ends on wrap
  wire ea_end = !ctrl_r.align_select && period_match;
  // single shot stop, on the tick that leaves the final count for zero
  wire sshot_stop = step && ctrl_r.single_shot_ctl && (ea_end || ca_end);

  // ----------------------------------------------------------------
  // next count and direction
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] cnt_up = pwm_counter_r + 1'b1;
  wire [CNT_W-1:0] cnt_down = pwm_counter_r - 1'b1;
  wire [CNT_W-1:0] cnt_edge = period_match ? '0 : cnt_up;
  // count by current flag, so turns lag the match by a tick
  wire [CNT_W-1:0] cnt_center = counting_down ? cnt_down : cnt_up;
  wire turn_down = !counting_down && period_match;
  wire turn_up = counting_down && one_match;
  // count writes only land while stopped, else the period would tear
  wire load_count = wr_count && !run_r;

  always_comb begin
    cnt_nxt = pwm_counter_r;
    dir_nxt = count_dir_flag_r;
    if (!ctrl_r.align_select) begin
      dir_nxt = 1'b0;
      if (step) begin
        cnt_nxt = cnt_edge;
      end
    end else if (step) begin
      cnt_nxt = cnt_center;
      if (turn_down) begin
        dir_nxt = 1'b1;
      end
      if (turn_up) begin
        dir_nxt = 1'b0;
      end
    end
    if (load_count) begin
      cnt_nxt = reg_wdata[CNT_W-1:0];
    end
  end

  // run set by software; hardware stop wins over a coincident set
  assign run_nxt = sshot_stop || run_clr ? 1'b0 : (run_set ? 1'b1 : run_r);

  // ----------------------------------------------------------------
  // counter, direction and run registers
  // ----------------------------------------------------------------
  // reset state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_counter_r <= '0;
    end else begin
      pwm_counter_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_dir_flag_r <= 1'b0;
    end else begin
      count_dir_flag_r <= dir_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control, period and mode registers
  // ----------------------------------------------------------------
  // only the two mode bits persist; every ctrl write rewrites them
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r.align_select <= reg_wdata[`TPWM_CTRL_ALIGN];
        ctrl_r.single_shot_ctl <= reg_wdata[`TPWM_CTRL_SSHOT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_shadow_r <= '0;
    end else begin
      if (wr_period) begin
        period_shadow_r <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // a same-cycle write joins the transfer so no stale value is used
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_reg_r <= '0;
    end else begin
      if (shadow_xfer) begin
        period_reg_r <= wr_period ? reg_wdata[CNT_W-1:0] : period_shadow_r;
      end
    end
  end

  // mode codes other than hysteresis act as normal compare
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      channel_mode_sel_r <= '0;
    end else begin
      if (wr_mode) begin
        channel_mode_sel_r <= reg_wdata[4*NCH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // hysteresis input sampling
  // ----------------------------------------------------------------
  // sampled every module clock
  // the extra flop delays the gate by one clock, never by a tick
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hyst_s_r <= '0;
    end else begin
      hyst_s_r <= hyst_input;
    end
  end

  // ----------------------------------------------------------------
  // compare channels
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      // each channel owns one nibble of the mode register
      wire [3:0] mode = channel_mode_sel_r[4*ch +: 4];
      wire hyst_mode = mode == `TPWM_MODE_HYST;
      wire wr_cmp = reg_wr && reg_addr == `TPWM_ADDR_W'(`TPWM_OFF_CMP0 + ch);
      wire cmd_set = wr_stcmd && reg_wdata[`TPWM_STCMD_SET + ch];
      wire cmd_clr = wr_stcmd && reg_wdata[`TPWM_STCMD_CLR + ch];

      assign compare_match[ch] = pwm_counter_r == compare_value_r[ch];
      // set on up match, incl zero with match
      wire up_hit = !counting_down && compare_match[ch];
      wire down_hit = counting_down && compare_match[ch];
      // zero pass with no match starts the low part of the period
      wire zero_miss = !counting_down && zero_match && !compare_match[ch];
      wire rule_set = step && up_hit;
      // clear on down match or zero without match
      wire rule_clr = step && (down_hit || zero_miss);
      // a low sampled input overrides even a software set command
      wire hyst_block = hyst_mode && !hyst_s_r[ch];

      logic st_nxt;
      always_comb begin
        st_nxt = state_r[ch];
        if (rule_set) begin
          st_nxt = 1'b1;
        end else if (rule_clr) begin
          st_nxt = 1'b0;
        end
        if (cmd_set) begin
          st_nxt = 1'b1;
        end else if (cmd_clr) begin
          st_nxt = 1'b0;
        end
        // hysteresis gate only in its mode
        if (hyst_block) begin
          st_nxt = 1'b0;
        end
      end
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          state_r[ch] <= 1'b0;
        end else begin
          state_r[ch] <= st_nxt;
        end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          compare_shadow_r[ch] <= '0;
        end else begin
          if (wr_cmp) begin
            compare_shadow_r[ch] <= reg_wdata[CNT_W-1:0];
          end
        end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          compare_value_r[ch] <= '0;
        end else begin
          if (shadow_xfer) begin
            compare_value_r[ch] <= wr_cmp ? reg_wdata[CNT_W-1:0]
                                          : compare_shadow_r[ch];
          end
        end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          rise_r[ch] <= 1'b0;
        end else begin
          rise_r[ch] <= step && up_hit;
        end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          fall_r[ch] <= 1'b0;
        end else begin
          fall_r[ch] <= step && down_hit;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  assign channel_state = state_r;
  assign cmp_evt.cmp_rise_evt = rise_r;
  assign cmp_evt.cmp_fall_evt = fall_r;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // command bits read as zero: they act once and are not stored
  wire [15:0] ctrl_word = {14'h0000, ctrl_r.single_shot_ctl,
                           ctrl_r.align_select};
  wire [15:0] stat_word = {9'h000, state_r, 2'h0, count_dir_flag_r, run_r};
  wire [15:0] mode_word = {4'h0, channel_mode_sel_r};
  wire [15:0] period_word = 16'(period_reg_r);

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      `TPWM_OFF_CTRL: rd_mux = ctrl_word;
      `TPWM_OFF_STAT: rd_mux = stat_word;
      `TPWM_OFF_PERIOD: rd_mux = period_word;
      `TPWM_OFF_CMP0: rd_mux = compare_shadow_r[0];
      `TPWM_OFF_CMP1: rd_mux = compare_shadow_r[1];
      `TPWM_OFF_CMP2: rd_mux = compare_shadow_r[2];
      `TPWM_OFF_MODE: rd_mux = mode_word;
      `TPWM_OFF_COUNT: rd_mux = pwm_counter_r;
      // unmapped indices read zero
      default: rd_mux = 16'h0000;
    endcase
  end

  // data stand one cycle only; idle cycles read zero
  wire [15:0] rd_next = reg_rd ? rd_mux : 16'h0000;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rd_next;
    end
  end

endmodule

// [test/tpwm_ocp_model.sv]
// overcurrent comparator model that drives the hysteresis inputs
`timescale 1ns/1ps
module tpwm_ocp_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] trip,
  output logic [2:0] hyst_input
);
  // registered output, so the level only moves just after an edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      hyst_input <= 3'h7;
    else
      hyst_input <= ~trip;
  end
endmodule

// [test/tpwm_timer_chk.sv]
// port-level assertions for the pwm timer
`timescale 1ns/1ps
`include "tpwm_cfg.svh"
module tpwm_chk
  import tpwm_pkg::*;
#(parameter int CNT_W = 16, parameter int NCH = 3) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic timer_tick,
  input wire logic [NCH-1:0] hyst_input,
  input wire logic [`TPWM_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [NCH-1:0] channel_state,
  input wire tpwm_evt_type cmp_evt,
  input wire logic period_match,
  input wire logic zero_match,
  input wire logic one_match,
  input wire logic run_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  property p_excl; !(zero_match && one_match); endproperty
  a_excl: assert property (p_excl) else $error("zero and one match");
  property p_evt; (cmp_evt.cmp_rise_evt & cmp_evt.cmp_fall_evt) == '0;
  endproperty
  a_evt: assert property (p_evt) else $error("rise and fall at once");
  property p_src; |cmp_evt |-> $past(run_flag) && $past(timer_tick);
  endproperty
  a_src: assert property (p_src) else $error("event without a step");
  // register writes are excluded: set commands may raise bits
  property p_hold; !$past(run_flag) && !$past(reg_wr) |->
    (channel_state & ~$past(channel_state)) == '0; endproperty
  a_hold: assert property (p_hold) else $error("state rose stopped");
  property p_pm; period_match && run_flag && timer_tick && !reg_wr |=>
    !period_match; endproperty
  a_pm: assert property (p_pm) else $error("stuck on period");
  property p_zm; zero_match && run_flag && timer_tick && !reg_wr |=>
    one_match || zero_match; endproperty
  a_zm: assert property (p_zm) else $error("bad step from zero");
  property p_stop; $fell(run_flag) |-> zero_match || $past(reg_wr);
  endproperty
  a_stop: assert property (p_stop) else $error("stop off zero");
  property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  // a low hysteresis input (seen one flop late) may veto the set
  property p_cmd; reg_wr && reg_addr == `TPWM_OFF_STCMD |=>
    (channel_state & $past(reg_wdata[2:0]) & $past(hyst_input, 2)) ==
    ($past(reg_wdata[2:0]) & $past(hyst_input, 2));
  endproperty
  a_cmd: assert property (p_cmd) else $error("set command lost");
  cover property (|cmp_evt.cmp_fall_evt);
  cover property ($fell(run_flag));
  cover property (reg_wr && reg_addr == `TPWM_OFF_STCMD);
endmodule
bind tpwm_timer tpwm_chk #(.CNT_W(CNT_W), .NCH(NCH)) tpwm_chk_i (
  .sys_clk, .nrst, .timer_tick, .hyst_input, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd,
  .reg_rdata, .channel_state, .cmp_evt, .period_match, .zero_match,
  .one_match, .run_flag
);

// [test/tb.sv]
// self-checking bench for the pwm timer
`timescale 1ns/1ps
`include "tpwm_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  miscompares++; $display("Error at %0t got %h exp %h", $time, a, b); \
  end end
module tb
  import tpwm_pkg::*;
;
  typedef struct {logic w; logic [3:0] a; logic [15:0] d, e;} tpwm_row_type;
  localparam int P = 5;
  logic sys_clk = 0, nrst = 0, timer_tick = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [2:0] hyst_input, channel_state, trip = 3'h0;
  tpwm_evt_type cmp_evt;
  logic period_match, zero_match, one_match, run_flag;
  int miscompares = 0, cmp_count = 0, n;
  int cv[3] = '{2, 0, 6};
  tpwm_row_type rows[14] = '{
    '{1'h0, `TPWM_OFF_STAT, 16'h0, 16'h0}, '{1'h0, `TPWM_OFF_PERIOD, 16'h0, 16'h0},
    '{1'h0, `TPWM_OFF_CMP1, 16'h0, 16'h0}, '{1'h0, `TPWM_OFF_COUNT, 16'h0, 16'h0},
    '{1'h1, `TPWM_OFF_PERIOD, 16'h5, 16'h0}, '{1'h1, `TPWM_OFF_CMP0, 16'h2, 16'h0},
    '{1'h1, `TPWM_OFF_CMP2, 16'h6, 16'h0}, '{1'h0, `TPWM_OFF_PERIOD, 16'h0, 16'h0},
    '{1'h0, `TPWM_OFF_CMP2, 16'h0, 16'h6}, '{1'h1, `TPWM_OFF_MODE, 16'h119, 16'h0},
    '{1'h1, `TPWM_OFF_CTRL, 16'h10, 16'h0}, '{1'h0, `TPWM_OFF_PERIOD, 16'h0, 16'h5},
    '{1'h1, 4'hf, 16'hffff, 16'h0}, '{1'h0, 4'hf, 16'h0, 16'h0}};
  always #50 sys_clk = ~sys_clk;
  tpwm_timer tpwm_timer_i (
    .sys_clk, .nrst, .timer_tick, .hyst_input, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .channel_state, .cmp_evt,
    .period_match, .zero_match, .one_match, .run_flag);
  tpwm_ocp_model tpwm_ocp_model_i (.sys_clk, .nrst, .trip, .hyst_input);
  // ----------------------------------------------------------
  // bus and timing tasks
  // ----------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    `CHK(reg_rdata, e)
  endtask
  task automatic wait_zero();
    int k = 0;
    do @(negedge sys_clk); while (zero_match !== 1'h0 && k++ < 40);
    do @(negedge sys_clk); while (zero_match !== 1'h1 && k++ < 80);
    `CHK(zero_match, 1'h1)
  endtask
  // edge mode checks every tick; center mode only tallies the events
  task automatic run_period(input logic c, input logic [2:0] m);
    logic [2:0] st, er, rs, fs;
    int len;
    len = c ? 2 * P + 2 : P + 1;
    rs = 3'h0;
    fs = 3'h0;
    wait_zero();
    for (int j = 0; j < len; j++) begin
      for (int k = 0; k < 3; k++) begin
        st[k] = m[k] && cv[k] <= P && (j > cv[k] || j == 0);
        er[k] = j == cv[k] + 1;
      end
      if (!c) begin
        `CHK(channel_state, st)
        `CHK(cmp_evt, {er, 3'h0})
      end
      rs |= cmp_evt.cmp_rise_evt;
      fs |= cmp_evt.cmp_fall_evt;
      @(negedge sys_clk);
    end
    `CHK(zero_match, 1'h1)
    if (c) `CHK({rs, fs}, 6'h1d)
  endtask
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'h1;
    @(negedge sys_clk);
    `CHK({channel_state, run_flag, zero_match, one_match}, 6'h02)
    foreach (rows[i])
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].e);
    wr(`TPWM_OFF_STCMD, 16'h0077);
    rd(`TPWM_OFF_STAT, 16'h0070);
    wr(`TPWM_OFF_STCMD, 16'h0070);
    rd(`TPWM_OFF_STAT, 16'h0000);
    wr(`TPWM_OFF_CTRL, 16'h0004);
    run_period(1'h0, 3'h7);
    @(posedge sys_clk);
    trip <= 3'h3;
    run_period(1'h0, 3'h6);
    @(posedge sys_clk);
    trip <= 3'h0;
    wait_zero();
    run_period(1'h0, 3'h7);
    wr(`TPWM_OFF_CTRL, 16'h0005);
    run_period(1'h1, 3'h7);
    // stop first: an edge-mode counter above the period would run away
    wr(`TPWM_OFF_CTRL, 16'h0009);
    wr(`TPWM_OFF_COUNT, 16'h0000);
    for (int a = 0; a < 2; a++) begin
      wr(`TPWM_OFF_CTRL, 16'h0006 | 16'(a));
      n = 0;
      do @(negedge sys_clk); while (run_flag === 1'h1 && n++ < 40);
      `CHK(n, a ? 2 * P + 2 : P + 1)
      repeat (3) @(negedge sys_clk);
      `CHK({run_flag, zero_match}, 2'h1)
    end
    summarize();
  end
  initial begin
    #500_000;
    miscompares++;
    summarize();
  end
endmodule
